// file: verilog/core_program_memory_access.sv
// Program counter, return stack, indirect pointers and memory access
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Return stack: 16 entries, 15 bits wide
// - Overflow/underflow set sticky status flags
// - Stack error pulses soft reset when enabled
// - Two 16-bit pointers reach all memory
// - Program memory indirect access costs extra cycle
// - Linear pointer view spans 80-byte GPR banks
// - Program counter 15 bits, 32K word space
// - Addresses wrap within implemented program words
// - Reset starts 0000h, interrupt vectors 0004h
// - Top 128 words form high-endurance region
// - High endurance covers only low byte
// - Pointer bit 15 selects program memory reads
// - Program reads return low eight bits only
// - Indirect writes never alter program memory
// - Interrupt shadows context, retfie restores it
// - Decoder supports a 49-instruction set
// - Data address: 5-bit bank, 7-bit offset
// - Unimplemented data locations read zero
module core_program_memory_access
  import core_mem_pkg::*;
#(
  parameter int PM_WORDS = PM_WORDS_DEF,
  parameter int N_INSTR = INSTR_COUNT
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Program flow requests
  input wire logic i_pc_step,
  input wire logic i_pc_load,
  input wire logic i_call,
  input wire logic i_return,
  input wire logic i_retfie,
  input wire logic i_irq_enter,
  input wire logic [PC_W-1:0] i_pc_target,
  // Stack status control
  input wire logic i_stack_err_reset_en,
  input wire logic i_stack_overflow_clr,
  input wire logic i_stack_underflow_clr,
  // Pointer writes
  input wire logic i_ptr_wr,
  input wire logic i_ptr_sel,
  input wire logic [PTR_W-1:0] i_ptr_wdata,
  // Indirect data port requests
  input wire logic i_ind_rd,
  input wire logic i_ind_wr,
  input wire logic [BYTE_W-1:0] i_ind_wdata,
  // Live core context for shadowing
  input wire logic [CTX_W-1:0] i_ctx_live,
  // Memory answers
  input wire logic [PM_DATA_W-1:0] i_pfm_rdata,
  input wire logic [BYTE_W-1:0] i_dm_rdata,
  input wire logic i_dm_implemented,
  // Program flow outputs
  output logic [PC_W-1:0] o_pc,
  output logic o_soft_reset,
  output logic o_stack_overflow_flag,
  output logic o_stack_underflow_flag,
  // Pointer and indirect outputs
  output logic [PTR_W-1:0] o_ptr0,
  output logic [PTR_W-1:0] o_ptr1,
  output logic o_busy,
  output logic o_ind_done,
  output logic [BYTE_W-1:0] o_ind_rdata,
  output logic o_hef_low_byte,
  // Context restore
  output logic o_ctx_restore,
  output logic [CTX_W-1:0] o_ctx_shadow,
  // Program flash read port
  output logic o_pfm_rd,
  output logic [PC_W-1:0] o_pfm_addr,
  // Data memory port
  output logic o_dm_rd,
  output logic o_dm_wr,
  output logic [DM_ADDR_W-1:0] o_dm_addr,
  output logic [BYTE_W-1:0] o_dm_wdata
);
  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (PM_WORDS != 1024 && PM_WORDS != 2048) begin : g_bad_pm_words
    $error("PM_WORDS must be 1024 or 2048");
  end
  if (N_INSTR != INSTR_COUNT) begin : g_bad_instr
    $error("Decoder serves exactly the 49-instruction set");
  end

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Fold any address into the implemented words
  function automatic logic [PC_W-1:0] pm_wrap(input logic [PC_W-1:0] a);
    pm_wrap = a & PC_W'(PM_WORDS - 1);
  endfunction : pm_wrap

  // Map a data pointer onto bank and offset; flag unreachable values
  function automatic logic [DM_ADDR_W:0] dm_map(input logic [PTR_W-1:0] p);
    logic [15:0] off;
    logic [15:0] bank;
    logic [15:0] low;
    off = p - LINEAR_BASE;
    bank = off / LINEAR_BYTES;
    low = off % LINEAR_BYTES;
    dm_map = '0;
    if (p < TRAD_LIMIT) begin
      dm_map = {1'b1, p[DM_ADDR_W-1:0]};
    end else if (p >= LINEAR_BASE && bank < 16'(BANK_COUNT)) begin
      dm_map = {1'b1, bank[4:0], low[6:0] + GPR_OFFSET};
    end
  endfunction : dm_map

  // ---------------------------------------------------------------
  // Program counter and stack
  // ---------------------------------------------------------------
  logic [PC_W-1:0] pc_r;          // Current program address
  logic [PC_W-1:0] pc_nxt;
  logic stk_push;                 // Call or interrupt entry
  logic stk_pop;                  // Return of either kind
  logic [PC_W-1:0] stk_top;       // Return address on top
  logic stk_ovf;                  // Push to a full stack
  logic stk_unf;                  // Pop of an empty stack
  logic ovf_r;
  logic ovf_nxt;
  logic unf_r;
  logic unf_nxt;
  logic srst_r;
  logic srst_nxt;

  // Only one flow request counts per cycle; interrupt entry wins
  assign stk_push = i_irq_enter || (i_call && !i_return && !i_retfie);
  assign stk_pop = !i_irq_enter && (i_return || i_retfie);

  return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_stack (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_push(stk_push),
    .i_pop(stk_pop),
    .i_push_data(pm_wrap(pc_r + 1'b1)),
    .o_top(stk_top),
    .o_overflow(stk_ovf),
    .o_underflow(stk_unf)
  );

  // Next program address and stack status
  always_comb begin
    pc_nxt = pc_r;
    if (i_irq_enter) begin
      pc_nxt = IRQ_VECTOR;
    end else if (stk_pop) begin
      pc_nxt = stk_top;
    end else if (i_call || i_pc_load) begin
      pc_nxt = pm_wrap(i_pc_target);
    end else if (i_pc_step) begin
      pc_nxt = pm_wrap(pc_r + 1'b1);
    end
    // A new error beats a clear in the same cycle
    ovf_nxt = stk_ovf || (ovf_r && !i_stack_overflow_clr);
    unf_nxt = stk_unf || (unf_r && !i_stack_underflow_clr);
    srst_nxt = i_stack_err_reset_en && (stk_ovf || stk_unf);
  end

  // Program flow registers; reset lands on the reset vector
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pc_r <= RESET_VECTOR;
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
      srst_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      ovf_r <= ovf_nxt;
      unf_r <= unf_nxt;
      srst_r <= srst_nxt;
    end
  end

  assign o_pc = pc_r;
  assign o_stack_overflow_flag = ovf_r;
  assign o_stack_underflow_flag = unf_r;
  assign o_soft_reset = srst_r;

  // ---------------------------------------------------------------
  // Pointers and context shadow
  // ---------------------------------------------------------------
  logic [PTR_W-1:0] ptr_r [2];    // Two independent pointers
  logic [PTR_W-1:0] ptr_nxt [2];
  logic [PTR_W-1:0] psh_r [2];    // Shadow copies of the pointers
  logic [PTR_W-1:0] psh_nxt [2];
  logic [CTX_W-1:0] ctx_r;        // Shadow of external core context
  logic [CTX_W-1:0] ctx_nxt;
  logic ctxr_r;
  logic ctxr_nxt;

  // Pointer updates, shadowing and restore; no stack use involved
  always_comb begin
    ptr_nxt = ptr_r;
    psh_nxt = psh_r;
    ctx_nxt = ctx_r;
    ctxr_nxt = 1'b0;
    if (i_irq_enter) begin
      psh_nxt = ptr_r;
      ctx_nxt = i_ctx_live;
    end else if (i_retfie) begin
      ptr_nxt = psh_r;
      ctxr_nxt = 1'b1;
    end else if (i_ptr_wr) begin
      ptr_nxt[i_ptr_sel] = i_ptr_wdata;
    end
  end

  // Pointer and shadow registers
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ptr_r <= '{default: '0};
      psh_r <= '{default: '0};
      ctx_r <= '0;
      ctxr_r <= 1'b0;
    end else begin
      ptr_r <= ptr_nxt;
      psh_r <= psh_nxt;
      ctx_r <= ctx_nxt;
      ctxr_r <= ctxr_nxt;
    end
  end

  assign o_ptr0 = ptr_r[0];
  assign o_ptr1 = ptr_r[1];
  assign o_ctx_shadow = ctx_r;
  assign o_ctx_restore = ctxr_r;

  // ---------------------------------------------------------------
  // Indirect access sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DM_WAIT = 2'b01,
    ST_PM_FETCH = 2'b10,
    ST_PM_EXTRA = 2'b11
  } ind_state_t;

  ind_state_t st_r;
  ind_state_t st_nxt;
  logic [PTR_W-1:0] cur_ptr;      // Pointer named by the request
  logic [DM_ADDR_W:0] dm_hit;     // Reachable flag and data address
  logic [PC_W-1:0] pm_a;          // Wrapped program address
  logic dmnone_r;                 // Pointer reached no data location
  logic dmnone_nxt;
  logic pmrd_r;
  logic pmrd_nxt;
  logic [PC_W-1:0] pma_r;
  logic [PC_W-1:0] pma_nxt;
  logic dmrd_r;
  logic dmrd_nxt;
  logic dmwr_r;
  logic dmwr_nxt;
  logic [DM_ADDR_W-1:0] dma_r;
  logic [DM_ADDR_W-1:0] dma_nxt;
  logic [BYTE_W-1:0] dmw_r;
  logic [BYTE_W-1:0] dmw_nxt;
  logic done_r;
  logic done_nxt;
  logic [BYTE_W-1:0] rdat_r;
  logic [BYTE_W-1:0] rdat_nxt;
  logic hef_r;
  logic hef_nxt;

  assign cur_ptr = ptr_r[i_ptr_sel];
  assign dm_hit = dm_map(cur_ptr);
  assign pm_a = pm_wrap(cur_ptr[PC_W-1:0]);

  // Request decode and completion; a program read spends one more cycle
  always_comb begin
    st_nxt = st_r;
    dmnone_nxt = dmnone_r;
    pmrd_nxt = 1'b0;
    pma_nxt = pma_r;
    dmrd_nxt = 1'b0;
    dmwr_nxt = 1'b0;
    dma_nxt = dma_r;
    dmw_nxt = dmw_r;
    done_nxt = 1'b0;
    rdat_nxt = rdat_r;
    hef_nxt = hef_r;
    case (st_r)
      ST_IDLE: begin
        if (i_ind_rd && cur_ptr[PM_SEL_BIT]) begin
          // Program memory side of the pointer
          pmrd_nxt = 1'b1;
          pma_nxt = pm_a;
          hef_nxt = pm_a >= PC_W'(PM_WORDS - HEF_WORDS);
          st_nxt = ST_PM_FETCH;
        end else if (i_ind_rd) begin
          // Data memory side of the pointer
          dmrd_nxt = dm_hit[DM_ADDR_W];
          dma_nxt = dm_hit[DM_ADDR_W-1:0];
          dmnone_nxt = !dm_hit[DM_ADDR_W];
          hef_nxt = 1'b0;
          st_nxt = ST_DM_WAIT;
        end else if (i_ind_wr) begin
          // Program side and unreachable writes are dropped; reachable data side writes go out
          dmwr_nxt = !cur_ptr[PM_SEL_BIT] && dm_hit[DM_ADDR_W];
          dma_nxt = dm_hit[DM_ADDR_W-1:0];
          dmw_nxt = i_ind_wdata;
          done_nxt = 1'b1;
        end
      end
      ST_DM_WAIT: begin
        // Holes and unreachable pointers read as zero
        rdat_nxt = (dmnone_r || !i_dm_implemented) ? '0 : i_dm_rdata;
        done_nxt = 1'b1;
        st_nxt = ST_IDLE;
      end
      ST_PM_FETCH: begin
        // Only the low byte of the word reaches the working register
        rdat_nxt = i_pfm_rdata[BYTE_W-1:0];
        st_nxt = ST_PM_EXTRA;
      end
      ST_PM_EXTRA: begin
        done_nxt = 1'b1;
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= ST_IDLE;
      dmnone_r <= 1'b0;
      pmrd_r <= 1'b0;
      pma_r <= '0;
      dmrd_r <= 1'b0;
      dmwr_r <= 1'b0;
      dma_r <= '0;
      dmw_r <= '0;
      done_r <= 1'b0;
      rdat_r <= '0;
      hef_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      dmnone_r <= dmnone_nxt;
      pmrd_r <= pmrd_nxt;
      pma_r <= pma_nxt;
      dmrd_r <= dmrd_nxt;
      dmwr_r <= dmwr_nxt;
      dma_r <= dma_nxt;
      dmw_r <= dmw_nxt;
      done_r <= done_nxt;
      rdat_r <= rdat_nxt;
      hef_r <= hef_nxt;
    end
  end

  assign o_busy = (st_r != ST_IDLE);
  assign o_pfm_rd = pmrd_r;
  assign o_pfm_addr = pma_r;
  assign o_dm_rd = dmrd_r;
  assign o_dm_wr = dmwr_r;
  assign o_dm_addr = dma_r;
  assign o_dm_wdata = dmw_r;
  assign o_ind_done = done_r;
  assign o_ind_rdata = rdat_r;
  assign o_hef_low_byte = hef_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  property p_irq_vector;
    i_irq_enter |=> (o_pc == IRQ_VECTOR);
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("no interrupt vector");

  property p_pc_wrap;
    o_pc < PC_W'(PM_WORDS);
  endproperty
  a_pc_wrap: assert property (p_pc_wrap) else $error("pc beyond memory");

  property p_call_return;
    (i_call && !i_irq_enter && !i_return && !i_retfie && !stk_ovf) ##1
    (i_return && !i_irq_enter) |=> (o_pc == pm_wrap($past(o_pc, 2) + 1'b1));
  endproperty
  a_call_return: assert property (p_call_return) else $error("bad return address");

  property p_ovf_flag;
    stk_ovf |=> o_stack_overflow_flag;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow lost");

  property p_soft_reset;
    (stk_unf && i_stack_err_reset_en) |=> o_soft_reset;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("no soft reset");

  property p_pm_latency;
    (st_r == ST_IDLE && i_ind_rd && cur_ptr[PM_SEL_BIT]) |=>
    o_pfm_rd && !o_ind_done ##1 !o_ind_done ##1 o_ind_done;
  endproperty
  a_pm_latency: assert property (p_pm_latency) else $error("program read timing");

  property p_dm_latency;
    (st_r == ST_IDLE && i_ind_rd && !cur_ptr[PM_SEL_BIT]) |=> ##1 o_ind_done;
  endproperty
  a_dm_latency: assert property (p_dm_latency) else $error("data read timing");

  property p_pm_no_write;
    (st_r == ST_IDLE && !i_ind_rd && i_ind_wr && cur_ptr[PM_SEL_BIT]) |=> !o_dm_wr;
  endproperty
  a_pm_no_write: assert property (p_pm_no_write) else $error("program write leaked");

  property p_dm_zero;
    (st_r == ST_DM_WAIT && !i_dm_implemented) |=> (o_ind_rdata == '0);
  endproperty
  a_dm_zero: assert property (p_dm_zero) else $error("hole not zero");

  property p_ctx_restore;
    i_irq_enter ##1 (i_retfie && !i_irq_enter) |=> (o_ptr0 == $past(o_ptr0, 2));
  endproperty
  a_ctx_restore: assert property (p_ctx_restore) else $error("context not restored");
endmodule : core_program_memory_access
`default_nettype wire

// file: shared/core_mem_pkg.sv
// Shared constants for the core program/data memory access block
package core_mem_pkg;
  // ---------------------------------------------------------------
  // Program counter and vectors
  // ---------------------------------------------------------------
  localparam int PC_W = 15;
  localparam int PM_DATA_W = 14;
  localparam logic [14:0] RESET_VECTOR = 15'h0000;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  localparam int PM_WORDS_DEF = 1024;
  localparam int HEF_WORDS = 128;
  // ---------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------
  localparam int STACK_DEPTH = 16;
  localparam int STACK_CNT_W = 5;
  // ---------------------------------------------------------------
  // Indirect pointers and data memory
  // ---------------------------------------------------------------
  localparam int PTR_W = 16;
  localparam int PM_SEL_BIT = 15;
  localparam int DM_ADDR_W = 12;
  localparam int BANK_COUNT = 32;
  localparam logic [15:0] LINEAR_BASE = 16'h2000;
  localparam logic [15:0] LINEAR_BYTES = 16'h0050;
  localparam logic [6:0] GPR_OFFSET = 7'h20;
  localparam logic [15:0] TRAD_LIMIT = 16'h1000;
  localparam int BYTE_W = 8;
  // ---------------------------------------------------------------
  // Core and timing
  // ---------------------------------------------------------------
  localparam int INSTR_COUNT = 49;
  localparam int PM_EXTRA_CYCLES = 1;
  localparam int CTX_W = 32;
endpackage : core_mem_pkg

// file: verilog/return_stack.sv
// Hardware return-address stack with overflow and underflow detection
`timescale 1ns/1ps
`default_nettype none
module return_stack
  import core_mem_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_W
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Stack operations
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [WIDTH-1:0] i_push_data,
  // Results
  output logic [WIDTH-1:0] o_top,
  output logic o_overflow,
  output logic o_underflow
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] mem_r [DEPTH];   // Return addresses
  logic [STACK_CNT_W-1:0] cnt_r;     // Entries in use
  logic [STACK_CNT_W-1:0] cnt_nxt;

  // Geometry other than 16 entries of 15 bits is refused at elaboration; the depth counter is sized for 16
  if (DEPTH != STACK_DEPTH || WIDTH != PC_W) begin : g_bad_geometry
    $error("return_stack: unsupported geometry");
  end

  // Overflow on a push to a full stack, underflow on a pop of an empty one
  assign o_overflow = i_push && (cnt_r == STACK_CNT_W'(DEPTH));
  assign o_underflow = i_pop && (cnt_r == '0);
  // Empty stack pops zero rather than stale data
  assign o_top = (cnt_r == '0) ? '0 : mem_r[4'(cnt_r - 1'b1)];

  // Next depth
  always_comb begin
    cnt_nxt = cnt_r;
    if (i_push && !o_overflow) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (i_pop && !o_underflow) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Depth register
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Entry write; a full stack keeps its entries
  always_ff @(posedge i_ref_clk) begin
    if (i_push && !o_overflow) begin
      mem_r[cnt_r[3:0]] <= i_push_data;
    end
  end
endmodule : return_stack
`default_nettype wire

// file: test/mem_partner_model.sv
// Behavioural program flash and banked data memory seen by the block
`timescale 1ns/1ps
`default_nettype none
module mem_partner_model
  import core_mem_pkg::*;
(
  // Clock
  input wire logic i_ref_clk,
  // Requests from the block
  input wire logic i_pfm_rd,
  input wire logic [PC_W-1:0] i_pfm_addr,
  input wire logic i_dm_rd,
  input wire logic i_dm_wr,
  input wire logic [DM_ADDR_W-1:0] i_dm_addr,
  input wire logic [BYTE_W-1:0] i_dm_wdata,
  // Answers to the block
  output logic [PM_DATA_W-1:0] o_pfm_rdata,
  output logic [BYTE_W-1:0] o_dm_rdata,
  output logic o_dm_implemented
);
  // ----
  // Storage
  // ----
  logic [BYTE_W-1:0] mem_r [0:4095]; // Byte array seeded from its address
  logic [7:0] junk_r = 8'h00; // Moves every cycle, shown while idle
  initial begin
    for (int a = 0; a < 4096; a++) begin
      mem_r[a] = a[7:0] ^ 8'h5a;
    end
  end
  // Writes land on the edge; array keeps them even where unimplemented
  always @(posedge i_ref_clk) begin
    junk_r <= junk_r + 8'h3b;
    if (i_dm_wr) begin
      mem_r[i_dm_addr] <= i_dm_wdata;
    end
  end
  // ----
  // Answers
  // ----
  // Same-cycle answer while strobed; idle lines never hold the last value
  always_comb begin
    o_pfm_rdata = i_pfm_rd ? ({i_pfm_addr[5:0], i_pfm_addr[7:0]} ^ 14'h2b61)
                           : {junk_r[5:0], junk_r};
    o_dm_implemented = i_dm_rd ? (i_dm_addr[11:7] < 5'h04) : junk_r[0];
    o_dm_rdata = i_dm_rd ? mem_r[i_dm_addr] : ~junk_r;
  end
endmodule : mem_partner_model
`default_nettype wire

// file: test/core_program_memory_access_tb_top.sv
// Self-checking bench for the program/data memory access block
`timescale 1ns/1ps
`default_nettype none
module core_program_memory_access_tb_top;
  import core_mem_pkg::*;
  // ----
  // Stimulus and wiring
  // ----
  localparam int PMW = 1024; // Smaller variant
  logic i_ref_clk = 1'b0, i_resetn = 1'b0;
  logic i_pc_step = 1'b0, i_pc_load = 1'b0, i_call = 1'b0, i_return = 1'b0;
  logic i_retfie = 1'b0, i_irq_enter = 1'b0, i_stack_err_reset_en = 1'b0;
  logic i_stack_overflow_clr = 1'b0, i_stack_underflow_clr = 1'b0;
  logic i_ptr_wr = 1'b0, i_ptr_sel = 1'b0, i_ind_rd = 1'b0, i_ind_wr = 1'b0;
  logic [PC_W-1:0] i_pc_target = 15'h0000;
  logic [PTR_W-1:0] i_ptr_wdata = 16'h0000;
  logic [BYTE_W-1:0] i_ind_wdata = 8'h00;
  logic [CTX_W-1:0] i_ctx_live = 32'h00000000;
  logic [PM_DATA_W-1:0] i_pfm_rdata;
  logic [BYTE_W-1:0] i_dm_rdata, o_ind_rdata, o_dm_wdata;
  logic i_dm_implemented, o_soft_reset, o_stack_overflow_flag, o_stack_underflow_flag;
  logic o_busy, o_ind_done, o_hef_low_byte, o_ctx_restore, o_pfm_rd, o_dm_rd, o_dm_wr;
  logic [PC_W-1:0] o_pc, o_pfm_addr;
  logic [PTR_W-1:0] o_ptr0, o_ptr1;
  logic [CTX_W-1:0] o_ctx_shadow;
  logic [DM_ADDR_W-1:0] o_dm_addr;
  logic [31:0] lfsr = 32'h07cd2afc, live, r;
  logic [15:0] edge_ptr [6] = '{16'h837f, 16'h8380, 16'h204f, 16'h2050, 16'h29af, 16'h0fff};
  int fail_count = 0, num_checks = 0, cyc = 0;
  int pc = 0, ovf = 0, unf = 0, p0 = 0, p1 = 0, s0 = 0, s1 = 0;
  int stk [$]; // Reference return stack
  int dmem [int]; // Bytes written through the port
  always #2.5 i_ref_clk = ~i_ref_clk;
  core_program_memory_access #(.PM_WORDS(PMW)) core_program_memory_access_i (.*);
  mem_partner_model mem_partner_model_i (.i_ref_clk(i_ref_clk), .i_pfm_rd(o_pfm_rd),
    .i_pfm_addr(o_pfm_addr), .i_dm_rd(o_dm_rd), .i_dm_wr(o_dm_wr), .i_dm_addr(o_dm_addr),
    .i_dm_wdata(o_dm_wdata), .o_pfm_rdata(i_pfm_rdata), .o_dm_rdata(i_dm_rdata),
    .o_dm_implemented(i_dm_implemented));
  // ----
  // Reference model and helpers
  // ----
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Data address for a pointer, or -1 where it reaches nothing
  function automatic int dm_map(input int p);
    if (p < 'h1000) return p;
    if (p >= 'h2000 && p < 'h29b0) return ((p - 'h2000) / 80) * 128 + 'h20 + (p - 'h2000) % 80;
    return -1;
  endfunction : dm_map
  function automatic int exp_byte(input int p);
    int a;
    if (p[15]) return (((p & 'h7fff) % PMW) & 'hff) ^ 'h61;
    a = dm_map(p);
    if (a < 0 || a >= 512) return 0;
    return dmem.exists(a) ? dmem[a] : ((a & 'hff) ^ 'h5a);
  endfunction : exp_byte
  // One flow request: bit0 step, 1 load, 2 call, 3 return, 4 irq, 5 retfie
  task automatic flow(input logic [5:0] req, input logic [14:0] tgt);
    int err;
    int skip;
    err = 0;
    skip = 0;
    live = rnd();
    @(posedge i_ref_clk);
    {i_retfie, i_irq_enter, i_return, i_call, i_pc_load, i_pc_step} <= req;
    i_pc_target <= tgt;
    i_ctx_live <= live;
    @(posedge i_ref_clk);
    {i_retfie, i_irq_enter, i_return, i_call, i_pc_load, i_pc_step} <= 6'h00;
    #1;
    if (req[4] | req[2]) begin
      if (stk.size() == STACK_DEPTH) begin
        ovf = 1;
        err = 1;
        skip = 1;
      end else begin
        stk.push_back((pc + 1) % PMW);
      end
      pc = req[4] ? 4 : tgt % PMW;
    end else if (req[3] | req[5]) begin
      err = (stk.size() == 0);
      unf = unf | err;
      pc = err ? 0 : stk.pop_back();
    end else if (req[1]) begin
      pc = tgt % PMW;
    end else if (req[0]) begin
      pc = (pc + 1) % PMW;
    end
    if (!skip) chk(o_pc, pc);
    chk(o_stack_overflow_flag, ovf);
    chk(o_stack_underflow_flag, unf);
    chk(o_soft_reset, err & i_stack_err_reset_en);
    if (req[4]) begin
      s0 = p0;
      s1 = p1;
      chk(o_ctx_shadow, live);
    end
    if (req[5]) begin
      p0 = s0;
      p1 = s1;
      chk(o_ctx_restore, 1);
      chk({o_ptr1, o_ptr0}, {p1[15:0], p0[15:0]});
    end
  endtask : flow
  task automatic ptr_write(input logic sel, input logic [15:0] v);
    @(posedge i_ref_clk);
    i_ptr_wr <= 1'b1;
    i_ptr_sel <= sel;
    i_ptr_wdata <= v;
    @(posedge i_ref_clk);
    i_ptr_wr <= 1'b0;
    #1;
    if (sel) p1 = v;
    else p0 = v;
    chk(sel ? o_ptr1 : o_ptr0, v);
  endtask : ptr_write
  task automatic ind_read(input logic sel);
    int p;
    int n;
    p = sel ? p1 : p0;
    n = 1;
    @(posedge i_ref_clk);
    i_ind_rd <= 1'b1;
    i_ptr_sel <= sel;
    @(posedge i_ref_clk);
    i_ind_rd <= 1'b0;
    #1;
    chk(o_busy, 1);
    chk({o_pfm_rd, o_dm_rd}, {p[15], !p[15] && dm_map(p) >= 0});
    if (p[15]) chk(o_pfm_addr, (p & 'h7fff) % PMW);
    if (p[15]) chk(o_hef_low_byte, ((p & 'h7fff) % PMW) >= PMW - HEF_WORDS);
    if (!p[15] && dm_map(p) >= 0) chk(o_dm_addr, dm_map(p));
    while (o_ind_done !== 1'b1 && n < 8) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    chk(n, p[15] ? 3 : 2);
    chk(o_busy, 0);
    chk(o_ind_rdata, exp_byte(p));
  endtask : ind_read
  task automatic ind_write(input logic sel, input logic [7:0] d);
    int a;
    a = sel ? p1 : p0;
    a = a[15] ? -1 : dm_map(a);
    @(posedge i_ref_clk);
    i_ind_wr <= 1'b1;
    i_ptr_sel <= sel;
    i_ind_wdata <= d;
    @(posedge i_ref_clk);
    i_ind_wr <= 1'b0;
    #1;
    chk(o_ind_done, 1);
    chk(o_dm_wr, a >= 0);
    if (a >= 0) begin
      chk({o_dm_addr, o_dm_wdata}, {a[11:0], d});
      dmem[a] = d;
    end
  endtask : ind_write
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Cut a hang short
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    i_stack_err_reset_en <= 1'b1;
    #1;
    chk(o_pc, 0);
    flow(6'h02, 15'h0123);
    for (int k = 0; k < 17; k++) begin
      r = rnd();
      flow(6'h04, r[14:0]);
    end
    for (int k = 0; k < 16; k++) flow(6'h08, 15'h0000);
    flow(6'h08, 15'h0000);
    @(posedge i_ref_clk);
    i_stack_err_reset_en <= 1'b0;
    flow(6'h08, 15'h0000);
    @(posedge i_ref_clk);
    i_stack_overflow_clr <= 1'b1;
    i_stack_underflow_clr <= 1'b1;
    @(posedge i_ref_clk);
    i_stack_overflow_clr <= 1'b0;
    i_stack_underflow_clr <= 1'b0;
    ovf = 0;
    unf = 0;
    flow(6'h02, 15'h7fff);
    flow(6'h01, 15'h0000);
    $display("Test program flow done");
    ptr_write(1'b0, 16'h1234);
    ptr_write(1'b1, 16'h8abc);
    flow(6'h10, 15'h0000);
    ptr_write(1'b0, 16'h0055);
    flow(6'h20, 15'h0000);
    // Back-to-back push then pop: call/return, then interrupt/retfie
    for (int k = 0; k < 2; k++) begin
      @(posedge i_ref_clk);
      {i_irq_enter, i_call} <= k[0] ? 2'b10 : 2'b01;
      i_pc_target <= 15'h0200;
      @(posedge i_ref_clk);
      {i_irq_enter, i_call} <= 2'b00;
      {i_retfie, i_return} <= k[0] ? 2'b10 : 2'b01;
      @(posedge i_ref_clk);
      {i_retfie, i_return} <= 2'b00;
      #1;
      pc = (pc + 1) % PMW;
      chk(o_pc, pc);
      chk(o_ctx_restore, k[0]);
      chk({o_ptr1, o_ptr0}, {p1[15:0], p0[15:0]});
    end
    $display("Test context done");
    for (int k = 0; k < 6; k++) begin
      ptr_write(k[0], edge_ptr[k]);
      ind_read(k[0]);
    end
    for (int k = 0; k < 40; k++) begin
      r = rnd();
      case (r[17:16])
        2'd0: ptr_write(r[20], {4'h0, r[11:0]});
        2'd1: ptr_write(r[20], 16'h2000 + 16'(r[11:0] % 12'h9b0));
        2'd2: ptr_write(r[20], {1'b1, r[14:0]});
        default: ptr_write(r[20], {4'h3, r[11:0]});
      endcase
      if (r[21]) ind_write(r[20], r[31:24]);
      ind_read(r[20]);
    end
    $display("Test indirect access done");
    report_and_stop();
  end
endmodule : core_program_memory_access_tb_top
`default_nettype wire
